// [include/bg_monitor_cfg.svh]
// Register offsets, field positions, reset values and decode constants
`ifndef BG_MONITOR_CFG_SVH
`define BG_MONITOR_CFG_SVH

// ==================================================================
// Register offsets
`define ADDR_BG_FLAGS       8'h04
`define ADDR_BG_SETUP_A     8'h16
`define ADDR_BG_SETUP_B     8'h1c
`define ADDR_GAIN_CTRL_B    8'h44
`define ADDR_PATH_SEL_B     8'h45
`define ADDR_CH_GAIN_B      8'h55
`define ADDR_FLOAT_CTRL_B   8'h58

// ==================================================================
// Field positions
`define THRESH_MSB          13
`define COUNT_MSB           15
`define COUNT_LSB           14
`define FLAGS_A_LSB         0
`define FLAGS_B_LSB         4
`define GAIN_MSB            1
`define GAIN_LSB            0
`define PER_CH_GAIN_BIT     6
`define INT_BUF_BIT         7
`define CH_GAIN_LSB         6
`define CH_GAIN_MSB         11

// ==================================================================
// Reset values
`define RST_SETUP           16'h0000
// Upper front-end fields come up at their recommended codes; gain, split and buffer bits at 0
`define RST_GAIN_CTRL_B     16'h1c38
`define RST_PATH_SEL_B      16'hada5
`define RST_CH_GAIN_B       16'h0000
`define RST_FLOAT_CTRL_B    16'h0000

// ==================================================================
// Exceedance totals per count code
`define EXCEED_CODE1        5'h01
`define EXCEED_CODE2        5'h04
`define EXCEED_CODE3        5'h10

// ==================================================================
// Path select codes
`define PATH_FULL_CHAIN     16'hada5
`define PATH_AMP_ADC_BUF    16'hae65
`define PATH_AMP_ADC_INT    16'hb065

`endif

// [include/bg_monitor_pkg.sv]
// Types shared by the background light monitor
package bg_monitor_pkg;

  typedef enum logic [3:0] {
    PATH_FULL     = 4'b0001,
    PATH_AMP_ADC  = 4'b0010,
    PATH_RESERVED = 4'b0100,
    PATH_IDLE     = 4'b1000
  } path_mode_e;

  typedef enum logic [1:0] {
    GAIN_200K = 2'h0,
    GAIN_100K = 2'h1,
    GAIN_50K  = 2'h2,
    GAIN_25K  = 2'h3
  } gain_sel_e;

  typedef struct packed {
    logic [4:0] count;
    logic       flag;
  } chan_state_s;

endpackage

// [hw/exceed_counter.sv]
// One channel's exceedance counter and sticky background flag
`include "bg_monitor_cfg.svh"

module exceed_counter (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  // Sample and setup
  input  wire logic        sample_valid_i,
  input  wire logic [13:0] sample_i,
  input  wire logic [13:0] threshold_i,
  input  wire logic [1:0]  count_code_i,
  // Flag
  input  wire logic        flag_clear_i,
  output logic             flag_o
);

  bg_monitor_pkg::chan_state_s state_q;
  bg_monitor_pkg::chan_state_s state_d;
  logic [4:0]                  target;
  logic                        hit;
  logic [4:0]                  next_cnt;

  always_comb begin
    target   = 5'h00;
    hit      = sample_valid_i && (sample_i > threshold_i);
    next_cnt = state_q.count;
    state_d  = state_q;
    unique case (count_code_i)
      2'h0: target = 5'h00;
      2'h1: target = `EXCEED_CODE1;
      2'h2: target = `EXCEED_CODE2;
      2'h3: target = `EXCEED_CODE3;
    endcase
    // A read restarts the count; a hit in the same cycle still counts
    if (flag_clear_i) begin
      state_d.flag = 1'b0;
      next_cnt     = 5'h00;
    end
    // Saturate so a long run cannot wrap back below the target
    if (hit && next_cnt != 5'h1f) begin
      next_cnt = next_cnt + 5'h01;
    end
    state_d.count = next_cnt;
    if (target != 5'h00 && next_cnt >= target) begin
      state_d.flag = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign flag_o = state_q.flag;

endmodule

// [hw/background_light_threshold_monitor.sv]
// Float-mode background light monitor and slot B front-end setup registers
`include "bg_monitor_cfg.svh"

module background_light_threshold_monitor (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  // Register port
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  output logic [15:0]      reg_rdata_o,
  // Float-mode subtract samples
  input  wire logic        sample_valid_a_i,
  input  wire logic        sample_valid_b_i,
  input  wire logic [55:0] sample_a_i,
  input  wire logic [55:0] sample_b_i,
  // Slot B front-end setup
  output logic [7:0]       gain_b_o,
  output logic [3:0]       path_mode_b_o,
  output logic             integrator_buffer_mode_b_o
);

  typedef struct packed {
    logic [15:0] setup_a;
    logic [15:0] setup_b;
    logic [15:0] gain_ctrl_b;
    logic [15:0] path_sel_b;
    logic [15:0] ch_gain_b;
    logic [15:0] float_ctrl_b;
    logic [15:0] rdata;
    logic [7:0]  gain_b;
    logic [3:0]  path_mode;
    logic        int_buf;
  } regs_s;

  regs_s      regs_q;
  regs_s      regs_d;
  logic [7:0] flags;
  logic       flag_clear;
  logic [1:0] g1;
  logic [1:0] g2;
  logic [1:0] g3;
  logic [1:0] g4;
  bg_monitor_pkg::path_mode_e path_mode;

  // ==================================================================
  // Exceedance counters
  // Flags live in the counters, so the read clears them at the edge that
  // also returns them: the read sees the old value, the next hit wins.
  assign flag_clear = reg_rd_i && (reg_addr_i == `ADDR_BG_FLAGS);

  for (genvar ch = 0; ch < 4; ch++) begin : g_chan
    exceed_counter u_a (
      .sys_clk_i      (sys_clk_i),
      .rst_i          (rst_i),
      .sample_valid_i (sample_valid_a_i),
      .sample_i       (sample_a_i[ch*14 +: 14]),
      .threshold_i    (regs_q.setup_a[`THRESH_MSB:0]),
      .count_code_i   (regs_q.setup_a[`COUNT_MSB:`COUNT_LSB]),
      .flag_clear_i   (flag_clear),
      .flag_o         (flags[`FLAGS_A_LSB + ch])
    );
    exceed_counter u_b (
      .sys_clk_i      (sys_clk_i),
      .rst_i          (rst_i),
      .sample_valid_i (sample_valid_b_i),
      .sample_i       (sample_b_i[ch*14 +: 14]),
      .threshold_i    (regs_q.setup_b[`THRESH_MSB:0]),
      .count_code_i   (regs_q.setup_b[`COUNT_MSB:`COUNT_LSB]),
      .flag_clear_i   (flag_clear),
      .flag_o         (flags[`FLAGS_B_LSB + ch])
    );
  end

  // ==================================================================
  // Gain and path decode
  always_comb begin
    g1 = regs_q.gain_ctrl_b[`GAIN_MSB:`GAIN_LSB];
    g2 = g1;
    g3 = g1;
    g4 = g1;
    if (regs_q.gain_ctrl_b[`PER_CH_GAIN_BIT]) begin
      g2 = regs_q.ch_gain_b[`CH_GAIN_LSB +: 2];
      g3 = regs_q.ch_gain_b[`CH_GAIN_LSB + 2 +: 2];
      g4 = regs_q.ch_gain_b[`CH_GAIN_LSB + 4 +: 2];
    end
    unique case (regs_q.path_sel_b)
      `PATH_FULL_CHAIN:  path_mode = bg_monitor_pkg::PATH_FULL;
      `PATH_AMP_ADC_BUF: path_mode = bg_monitor_pkg::PATH_AMP_ADC;
      `PATH_AMP_ADC_INT: path_mode = bg_monitor_pkg::PATH_AMP_ADC;
      default:           path_mode = bg_monitor_pkg::PATH_RESERVED;
    endcase
  end

  // ==================================================================
  // Register file
  always_comb begin
    regs_d = regs_q;
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        `ADDR_BG_SETUP_A:   regs_d.setup_a      = reg_wdata_i;
        `ADDR_BG_SETUP_B:   regs_d.setup_b      = reg_wdata_i;
        `ADDR_GAIN_CTRL_B:  regs_d.gain_ctrl_b  = reg_wdata_i;
        `ADDR_PATH_SEL_B:   regs_d.path_sel_b   = reg_wdata_i;
        `ADDR_CH_GAIN_B:    regs_d.ch_gain_b    = reg_wdata_i;
        `ADDR_FLOAT_CTRL_B: regs_d.float_ctrl_b = reg_wdata_i;
        default:            regs_d.rdata        = regs_q.rdata;
      endcase
    end
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        `ADDR_BG_FLAGS:     regs_d.rdata = {8'h00, flags};
        `ADDR_BG_SETUP_A:   regs_d.rdata = regs_q.setup_a;
        `ADDR_BG_SETUP_B:   regs_d.rdata = regs_q.setup_b;
        `ADDR_GAIN_CTRL_B:  regs_d.rdata = regs_q.gain_ctrl_b;
        `ADDR_PATH_SEL_B:   regs_d.rdata = regs_q.path_sel_b;
        `ADDR_CH_GAIN_B:    regs_d.rdata = regs_q.ch_gain_b;
        `ADDR_FLOAT_CTRL_B: regs_d.rdata = regs_q.float_ctrl_b;
        default:            regs_d.rdata = 16'h0000;
      endcase
    end
    regs_d.gain_b    = {g4, g3, g2, g1};
    regs_d.path_mode = path_mode;
    regs_d.int_buf   = regs_q.gain_ctrl_b[`INT_BUF_BIT];
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      regs_q              <= '0;
      regs_q.setup_a      <= `RST_SETUP;
      regs_q.setup_b      <= `RST_SETUP;
      regs_q.gain_ctrl_b  <= `RST_GAIN_CTRL_B;
      regs_q.path_sel_b   <= `RST_PATH_SEL_B;
      regs_q.ch_gain_b    <= `RST_CH_GAIN_B;
      regs_q.float_ctrl_b <= `RST_FLOAT_CTRL_B;
      regs_q.path_mode    <= bg_monitor_pkg::PATH_IDLE;
    end else begin
      regs_q <= regs_d;
    end
  end

  // ==================================================================
  // Outputs
  assign reg_rdata_o                = regs_q.rdata;
  assign gain_b_o                   = regs_q.gain_b;
  assign path_mode_b_o              = regs_q.path_mode;
  assign integrator_buffer_mode_b_o = regs_q.int_buf;

endmodule

// [verification/bg_monitor_props.sv]
// Port-level assertions and covers for the background light monitor
module bg_monitor_props (
  // Clock and reset
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  // Register port
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic [15:0] reg_rdata_o,
  // Slot B setup
  input wire logic [7:0]  gain_b_o,
  input wire logic [3:0]  path_mode_b_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  wire logic rd_st = reg_rd_i && reg_addr_i == 8'h04;
  wire logic wr_g  = reg_wr_i && reg_addr_i == 8'h44;
  wire logic wr_p  = reg_wr_i && reg_addr_i == 8'h45;
  // ==================================================================
  // Assertions
  property p_hi; rd_st |=> reg_rdata_o[15:8] == 8'h00; endproperty
  a_hi: assert property (p_hi) else $error("status top byte set");
  property p_unm; reg_rd_i && reg_addr_i == 8'h30 |=> reg_rdata_o == 16'h0000; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_hold; !reg_rd_i |=> $stable(reg_rdata_o); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_full; wr_p && reg_wdata_i == 16'hada5 |-> ##2 path_mode_b_o == 4'b0001; endproperty
  a_full: assert property (p_full) else $error("full path not decoded");
  property p_amp;
    wr_p && (reg_wdata_i == 16'hae65 || reg_wdata_i == 16'hb065) |-> ##2 path_mode_b_o == 4'b0010;
  endproperty
  a_amp: assert property (p_amp) else $error("amp path not decoded");
  property p_rsv;
    wr_p && reg_wdata_i != 16'hada5 && reg_wdata_i != 16'hae65 && reg_wdata_i != 16'hb065
      |-> ##2 path_mode_b_o == 4'b0100;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved path not flagged");
  property p_gall;
    logic [1:0] g;
    (wr_g && !reg_wdata_i[6], g = reg_wdata_i[1:0]) |-> ##2 gain_b_o == {4{g}};
  endproperty
  a_gall: assert property (p_gall) else $error("shared gain wrong");
  property p_gone;
    logic [1:0] g;
    (wr_g && reg_wdata_i[6], g = reg_wdata_i[1:0]) |-> ##2 gain_b_o[1:0] == g;
  endproperty
  a_gone: assert property (p_gone) else $error("channel 1 gain wrong");
  // ==================================================================
  // Covers
  c_flag: cover property (rd_st ##1 reg_rdata_o[7:0] != 8'h00);
  c_split: cover property (wr_g && reg_wdata_i[6]);
  c_amp: cover property (path_mode_b_o == 4'b0010);
endmodule

bind background_light_threshold_monitor bg_monitor_props bg_monitor_props_i (
  .sys_clk_i, .rst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
  .gain_b_o, .path_mode_b_o);

// [verification/host_model.sv]
// Host side model driving the parallel register port
module host_model (
  // Clock and read data
  input  wire logic        sys_clk_i,
  input  wire logic [15:0] reg_rdata_i,
  // Strobes, address and data
  output logic             reg_wr_o,
  output logic             reg_rd_o,
  output logic [7:0]       reg_addr_o,
  output logic [15:0]      reg_wdata_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} = '0;
  end
  // Released address and data are inverted so a design never sees a stale word as valid
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge sys_clk_i);
    reg_wr_o <= 1'b1;
    reg_addr_o <= a;
    reg_wdata_o <= v;
    @(posedge sys_clk_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~v;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge sys_clk_i);
    reg_rd_o <= 1'b1;
    reg_addr_o <= a;
    @(posedge sys_clk_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    #1 v = reg_rdata_i;
  endtask
endmodule

// [verification/background_light_threshold_monitor_test.sv]
// Self-checking bench for the background light monitor
module background_light_threshold_monitor_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic        sys_clk_i, rst_i, reg_wr_i, reg_rd_i, sva, svb, ibuf;
  logic [7:0]  reg_addr_i, gain;
  logic [15:0] reg_wdata_i, reg_rdata_o, d;
  logic [55:0] sa, sb;
  logic [3:0]  pm;
  int          failures, checks_done;
  background_light_threshold_monitor background_light_threshold_monitor_i (
    .sys_clk_i, .rst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
    .sample_valid_a_i(sva), .sample_valid_b_i(svb), .sample_a_i(sa), .sample_b_i(sb),
    .gain_b_o(gain), .path_mode_b_o(pm), .integrator_buffer_mode_b_o(ibuf));
  host_model host_model_i (.sys_clk_i, .reg_rdata_i(reg_rdata_o), .reg_wr_o(reg_wr_i),
    .reg_rd_o(reg_rd_i), .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i));
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Back-to-back samples on both slots at once
  task automatic send(input int k);
    repeat (k) @(posedge sys_clk_i) {sva, svb} <= 2'b11;
    @(posedge sys_clk_i) {sva, svb} <= 2'b00;
  endtask
  task automatic t_reset();
    host_model_i.rd(8'h04, d);
    chk("flags", d, 16'h0000);
    host_model_i.rd(8'h16, d);
    chk("setup a", d, 16'h0000);
    host_model_i.rd(8'h45, d);
    chk("path reg", d, 16'hada5);
    host_model_i.rd(8'h44, d);
    chk("gain reg", d, 16'h1c38);
  endtask
  // A hit landing on the clearing read must restart the count and win over the clear
  task automatic t_clear_hit();
    host_model_i.wr(8'h16, 16'h4100);
    host_model_i.wr(8'h1c, 16'h0100);
    host_model_i.rd(8'h04, d);
    fork
      host_model_i.rd(8'h04, d);
      begin
        @(posedge sys_clk_i) sva <= 1'b1;
        @(posedge sys_clk_i) sva <= 1'b0;
      end
    join
    chk("old flags", d, 16'h0000);
    host_model_i.rd(8'h04, d);
    chk("set wins", d, 16'h000b);
    host_model_i.rd(8'h04, d);
    chk("cleared", d, 16'h0000);
  endtask
  task automatic t_count();
    int n[4] = '{16, 1, 4, 16};
    for (int c = 0; c < 4; c++) begin
      host_model_i.wr(8'h16, {c[1:0], 14'h0100});
      host_model_i.wr(8'h1c, {c[1:0], 14'h0100});
      host_model_i.rd(8'h04, d);
      send(n[c] - 1);
      host_model_i.rd(8'h04, d);
      chk("early", d, 16'h0000);
      send(n[c]);
      host_model_i.rd(8'h04, d);
      chk("flags", d, c == 0 ? 16'h0000 : 16'h00cb);
      host_model_i.rd(8'h04, d);
      chk("cleared", d, 16'h0000);
    end
  endtask
  task automatic t_gain();
    for (int g = 0; g < 4; g++) begin
      host_model_i.wr(8'h44, {14'h0, g[1:0]});
      repeat (2) @(posedge sys_clk_i);
      #1 chk("gain", {8'h0, gain}, {8'h0, {4{g[1:0]}}});
    end
    host_model_i.wr(8'h55, 16'h0e40);
    host_model_i.wr(8'h44, 16'h0042);
    repeat (2) @(posedge sys_clk_i);
    #1 chk("split", {8'h0, gain}, 16'h00e6);
  endtask
  task automatic t_path();
    logic [15:0] p[4] = '{16'hae65, 16'hb065, 16'h1234, 16'hada5};
    logic [15:0] b[4] = '{16'h0080, 16'h0000, 16'h0000, 16'h0000};
    logic [3:0]  m[4] = '{4'h2, 4'h2, 4'h4, 4'h1};
    host_model_i.wr(8'h58, 16'h0080);
    for (int i = 0; i < 4; i++) begin
      host_model_i.wr(8'h44, b[i]);
      host_model_i.wr(8'h45, p[i]);
      repeat (2) @(posedge sys_clk_i);
      #1 chk("path", {12'h0, pm}, {12'h0, m[i]});
      chk("buffer", {15'h0, ibuf}, {15'h0, b[i][7]});
    end
    host_model_i.rd(8'h30, d);
    chk("unmapped", d, 16'h0000);
  endtask
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  // Hang guard sized well above the few hundred cycles the sequence needs
  initial begin
    repeat (5000) @(posedge sys_clk_i);
    failures++;
    end_of_test();
  end
  initial begin
    rst_i = 1'b1;
    {sva, svb} = 2'b00;
    sa = {14'h0101, 14'h0100, 14'h0101, 14'h0101};
    sb = {14'h3fff, 14'h0101, 14'h0000, 14'h0100};
    repeat (8) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_count();
    t_clear_hit();
    t_gain();
    t_path();
    end_of_test();
  end
endmodule
